// [logic/icap_map.svh]
// Register offsets, field positions, reset values and timing counts for the capture channel
`ifndef ICAP_MAP_SVH
`define ICAP_MAP_SVH
`define ICAP_OFF_BUF 12'h000
`define ICAP_OFF_CON1 12'h004
`define ICAP_OFF_CON2 12'h008
`define ICAP_OFF_TMR 12'h00c
`define ICAP_OFF_PIN 12'h010
`define ICAP_CON1_RST 16'h0000
`define ICAP_CON2_RST 16'h000d
`define ICAP_TMR_RST 16'h0000
`define ICAP_CON1_WMASK 16'h3c67
`define ICAP_CON2_WMASK 16'h01df
`define ICAP_BIT_SIDL 13
`define ICAP_BIT_TSEL_HI 12
`define ICAP_BIT_TSEL_LO 10
`define ICAP_BIT_CPI_HI 6
`define ICAP_BIT_CPI_LO 5
`define ICAP_BIT_OV 4
`define ICAP_BIT_BNE 3
`define ICAP_BIT_MODE_HI 2
`define ICAP_BIT_MODE_LO 0
`define ICAP_BIT_CASC 8
`define ICAP_BIT_TRIGEN 7
`define ICAP_BIT_TSTAT 6
`define ICAP_BIT_SSEL_HI 4
`define ICAP_BIT_SSEL_LO 0
`define ICAP_MODE_OFF 3'h0
`define ICAP_MODE_BOTH 3'h1
`define ICAP_MODE_FALL 3'h2
`define ICAP_MODE_RISE 3'h3
`define ICAP_MODE_RISE4 3'h4
`define ICAP_MODE_RISE16 3'h5
`define ICAP_MODE_WAKE 3'h7
`define ICAP_PRESC_MAX4 4'h3
`define ICAP_PRESC_MAX16 4'hf
`define ICAP_FIFO_DEPTH 8
`define ICAP_DATA_W 16
`endif

// [logic/icap_pkg.sv]
// Types shared by the capture channel files
package icap_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } icap_req_type;
  typedef enum logic [1:0] {ICAP_IDLE = 2'h0, ICAP_SETUP = 2'h1, ICAP_ACCESS = 2'h3} icap_apb_type;
endpackage : icap_pkg

// [logic/icap_fifo.sv]
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
module icap_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic overflow
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [AW:0] count_r, count_nxt;
  logic push, pop;

  // Pointer and count arithmetic; a push into a full FIFO flags overflow and is dropped
  always_comb
  begin
    pop = outValid && outReady;
    push = inValid && inReady;
    wrPtr_nxt = push ? AW'(wrPtr_r + 1'b1) : wrPtr_r;
    rdPtr_nxt = pop ? AW'(rdPtr_r + 1'b1) : rdPtr_r;
    count_nxt = count_r;
    if (push && !pop)
    begin
      count_nxt = (AW+1)'(count_r + 1'b1);
    end
    else if (pop && !push)
    begin
      count_nxt = (AW+1)'(count_r - 1'b1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else if (ce)
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
      if (push)
      begin
        mem_r[wrPtr_r] <= inData;
      end
    end
  end

  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem_r[rdPtr_r];
  assign overflow = inValid && !inReady;
endmodule : icap_fifo

// [logic/icap_channel.sv]
// Input capture channel: APB registers, timer, edge capture, FIFO and DMA request
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "icap_map.svh"

// Functional notes
// - Enabling capture never alters pin direction
// - One DMA request per recorded capture while captures-per-interrupt is zero
// - Mode 111 plus irq enable wakes
// - Primary control layout, reset 0000
// - Secondary control layout, reset 000D
// - Timer resets zero, buffer undefined
// - Unimplemented control bits read zero
// - Trigger clear holds timer, captures zero
module icap_channel
  import icap_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capturePin,
  input wire logic captureIrqEnable,
  input wire logic sleepActive,
  input wire logic syncTrigIn,
  input wire logic timebaseTick,
  output logic pinDirection,
  output logic dmaRequest,
  output logic wakeRequest
);
  logic [15:0] con1_r, con1_nxt, con2_r, con2_nxt, tmr_r, tmr_nxt;
  logic pinDir_r, pinDir_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic dmaReq_r, dmaReq_nxt, wake_r, wake_nxt, ov_r, ov_nxt;
  logic [2:0] pinSync_r, trigSync_r;
  logic pinPrev_r, pinPrev_nxt, trigPrev_r, trigPrev_nxt;
  logic [3:0] presc_r, presc_nxt;
  logic rise, fall, capEvent, trigRise, bufPop, fifoValid, fifoReady, fifoOv;
  logic [15:0] fifoData;
  logic apbWr, apbRd;
  logic [2:0] mode;
  icap_req_type req;

  assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
  assign mode = con1_r[`ICAP_BIT_MODE_HI:`ICAP_BIT_MODE_LO];
  assign apbWr = psel && penable && !pready_r && req.pwrite;
  assign apbRd = psel && penable && !pready_r && !req.pwrite;
  assign bufPop = apbRd && (req.paddr == `ICAP_OFF_BUF) && fifoValid;

  // Pin and trigger inputs pass three flops; a change counts once stages two and three agree
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pinSync_r <= 3'h0;
      trigSync_r <= 3'h0;
    end
    else if (ce)
    begin
      pinSync_r <= {pinSync_r[1:0], capturePin};
      trigSync_r <= {trigSync_r[1:0], syncTrigIn};
    end
  end

  // Edge detection and capture prescaler
  always_comb
  begin
    pinPrev_nxt = pinPrev_r;
    trigPrev_nxt = trigPrev_r;
    if (pinSync_r[1] == pinSync_r[2])
    begin
      pinPrev_nxt = pinSync_r[2];
    end
    if (trigSync_r[1] == trigSync_r[2])
    begin
      trigPrev_nxt = trigSync_r[2];
    end
    rise = pinPrev_nxt && !pinPrev_r;
    fall = !pinPrev_nxt && pinPrev_r;
    trigRise = trigPrev_nxt && !trigPrev_r;
    presc_nxt = presc_r;
    capEvent = 1'b0;
    case (mode)
      `ICAP_MODE_BOTH: capEvent = rise || fall;
      `ICAP_MODE_FALL: capEvent = fall;
      `ICAP_MODE_RISE, `ICAP_MODE_WAKE: capEvent = rise;
      `ICAP_MODE_RISE4, `ICAP_MODE_RISE16:
      begin
        if (rise)
        begin
          if (presc_r == ((mode == `ICAP_MODE_RISE4) ? `ICAP_PRESC_MAX4 : `ICAP_PRESC_MAX16))
          begin
            capEvent = 1'b1;
            presc_nxt = 4'h0;
          end
          else
          begin
            presc_nxt = 4'(presc_r + 1'b1);
          end
        end
      end
      default: presc_nxt = 4'h0;
    endcase
  end

  // Captured timer values queue here; the DMA or software drains them
  icap_fifo #(.WIDTH(`ICAP_DATA_W), .DEPTH(`ICAP_FIFO_DEPTH)) u_icap_fifo (
    .clock(clock),
    .srst(srst),
    .ce(ce),
    .inValid(capEvent),
    .inReady(fifoReady),
    .inData(tmr_r),
    .outValid(fifoValid),
    .outReady(bufPop),
    .outData(fifoData),
    .overflow(fifoOv)
  );

  // Register writes, timer, trigger status, overflow and APB answer
  always_comb
  begin
    con1_nxt = con1_r;
    con2_nxt = con2_r;
    tmr_nxt = tmr_r;
    pinDir_nxt = pinDir_r;
    ov_nxt = ov_r || fifoOv;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt = 1'b0;
    if (apbWr)
    begin
      pready_nxt = 1'b1;
      if (req.paddr == `ICAP_OFF_CON1)
      begin
        con1_nxt = req.pwdata[15:0] & `ICAP_CON1_WMASK;
      end
      else if (req.paddr == `ICAP_OFF_CON2)
      begin
        con2_nxt = req.pwdata[15:0] & `ICAP_CON2_WMASK;
      end
      else if (req.paddr == `ICAP_OFF_TMR)
      begin
        tmr_nxt = req.pwdata[15:0];
      end
      else if (req.paddr == `ICAP_OFF_PIN)
      begin
        pinDir_nxt = req.pwdata[0];
      end
      else if (req.paddr != `ICAP_OFF_BUF)
      begin
        pslverr_nxt = 1'b1;
      end
    end
    else if (apbRd)
    begin
      pready_nxt = 1'b1;
      prdata_nxt = 32'h0000_0000;
      if (req.paddr == `ICAP_OFF_BUF)
      begin
        prdata_nxt = {16'h0000, fifoData};
      end
      else if (req.paddr == `ICAP_OFF_CON1)
      begin
        prdata_nxt = {16'h0000, con1_r | (16'(ov_r) << `ICAP_BIT_OV)
                     | (16'(fifoValid) << `ICAP_BIT_BNE)};
      end
      else if (req.paddr == `ICAP_OFF_CON2)
      begin
        prdata_nxt = {16'h0000, con2_r};
      end
      else if (req.paddr == `ICAP_OFF_TMR)
      begin
        prdata_nxt = {16'h0000, tmr_r};
      end
      else if (req.paddr == `ICAP_OFF_PIN)
      begin
        prdata_nxt = {31'h0, pinDir_r};
      end
      else
      begin
        pslverr_nxt = 1'b1;
      end
    end
    // Writing the overflow bit clear clears it unless a new overflow lands now
    if (apbWr && req.paddr == `ICAP_OFF_CON1 && !req.pwdata[`ICAP_BIT_OV] && !fifoOv)
    begin
      ov_nxt = 1'b0;
    end
    // Trigger status set by a sync rise; a software clear loses to a same-cycle rise
    if (con2_r[`ICAP_BIT_TRIGEN] && trigRise
        && con2_r[`ICAP_BIT_SSEL_HI:`ICAP_BIT_SSEL_LO] != 5'h00)
    begin
      con2_nxt[`ICAP_BIT_TSTAT] = 1'b1;
    end
    // Timer advances on the timebase tick while the capture mode is not off, unless held by trigger mode
    if (con2_r[`ICAP_BIT_TRIGEN] && !con2_r[`ICAP_BIT_TSTAT])
    begin
      tmr_nxt = `ICAP_TMR_RST;
    end
    else if (!(apbWr && req.paddr == `ICAP_OFF_TMR) && timebaseTick && mode != `ICAP_MODE_OFF)
    begin
      tmr_nxt = 16'(tmr_r + 1'b1);
    end
  end

  // DMA request pulses once per stored capture while the captures-per-interrupt field is zero; wake from sleep on a mode-7 rise
  always_comb
  begin
    dmaReq_nxt = capEvent && fifoReady && (con1_r[`ICAP_BIT_CPI_HI:`ICAP_BIT_CPI_LO] == 2'h0);
    wake_nxt = sleepActive && captureIrqEnable && (mode == `ICAP_MODE_WAKE) && rise;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      con1_r <= `ICAP_CON1_RST;
      con2_r <= `ICAP_CON2_RST;
      tmr_r <= `ICAP_TMR_RST;
      pinDir_r <= 1'b1;
      ov_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      dmaReq_r <= 1'b0;
      wake_r <= 1'b0;
      pinPrev_r <= 1'b0;
      trigPrev_r <= 1'b0;
      presc_r <= 4'h0;
    end
    else if (ce)
    begin
      con1_r <= con1_nxt;
      con2_r <= con2_nxt;
      tmr_r <= tmr_nxt;
      pinDir_r <= pinDir_nxt;
      ov_r <= ov_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      dmaReq_r <= dmaReq_nxt;
      wake_r <= wake_nxt;
      pinPrev_r <= pinPrev_nxt;
      trigPrev_r <= trigPrev_nxt;
      presc_r <= presc_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pinDirection = pinDir_r;
  assign dmaRequest = dmaReq_r;
  assign wakeRequest = wake_r;

  // Assertions
  property dmaPerCapture;
    @(posedge clock) disable iff (srst)
    (ce && capEvent && fifoReady && con1_r[`ICAP_BIT_CPI_HI:`ICAP_BIT_CPI_LO] == 2'h0)
    |=> dmaReq_r;
  endproperty
  dma_per_capture_a: assert property (dmaPerCapture)
    else $error("capture without dma request");
  dma_no_spurious_a: assert property (@(posedge clock) disable iff (srst)
    (ce && !capEvent) |=> !dmaReq_r)
    else $error("dma request without capture");
  pin_dir_kept_a: assert property (@(posedge clock) disable iff (srst)
    !(apbWr && paddr == `ICAP_OFF_PIN) |=> $stable(pinDir_r))
    else $error("pin direction moved");
  wake_on_rise_a: assert property (@(posedge clock) disable iff (srst)
    (ce && rise && mode == `ICAP_MODE_WAKE && captureIrqEnable && sleepActive) |=> wake_r)
    else $error("no wake on rise");
  // A wake pulse with no qualifying rise would rouse a sleeping device for nothing
  wake_no_spurious_a: assert property (@(posedge clock) disable iff (srst)
    (ce && !(rise && mode == `ICAP_MODE_WAKE && captureIrqEnable)) |=> !wake_r)
    else $error("wake without rise");
  con1_reserved_a: assert property (@(posedge clock) disable iff (srst)
    (con1_r & ~`ICAP_CON1_WMASK) == 16'h0000)
    else $error("reserved con1 bits set");
  con2_reserved_a: assert property (@(posedge clock) disable iff (srst)
    (con2_r & ~`ICAP_CON2_WMASK) == 16'h0000)
    else $error("reserved con2 bits set");
  read_upper_zero_a: assert property (@(posedge clock) disable iff (srst)
    pready_r |-> (prdata_r[31:16] == 16'h0000))
    else $error("upper read bits set");
  timer_held_a: assert property (@(posedge clock) disable iff (srst)
    (con2_r[`ICAP_BIT_TRIGEN] && !con2_r[`ICAP_BIT_TSTAT])
    |=> (tmr_r == `ICAP_TMR_RST || !$past(ce)))
    else $error("timer not held");
  sequence bufRead;
    ce && apbRd && paddr == `ICAP_OFF_BUF && fifoValid && !capEvent;
  endsequence
  buf_pop_a: assert property (@(posedge clock) disable iff (srst) bufRead
    |=> (u_icap_fifo.count_r == $past(u_icap_fifo.count_r) - 4'h1))
    else $error("read did not pop");
  // Overflow must survive a same-cycle software clear
  ov_set_wins_a: assert property (@(posedge clock) disable iff (srst)
    (ce && fifoOv) |=> ov_r)
    else $error("overflow lost");
  reset_values_a: assert property (@(posedge clock)
    $past(srst) |-> (con1_r == `ICAP_CON1_RST && con2_r == `ICAP_CON2_RST
    && tmr_r == `ICAP_TMR_RST))
    else $error("bad reset values");
  apb_answer_a: assert property (@(posedge clock) disable iff (srst)
    (ce && psel && penable && !pready_r) |=> pready_r)
    else $error("apb answer late");
  pready_pulse_a: assert property (@(posedge clock) disable iff (srst)
    (ce && pready_r) |=> !pready_r)
    else $error("apb answer held");
endmodule : icap_channel

// [testbench/icap_dma_model.sv]
// DMA controller model that drains the capture buffer over APB
`timescale 1ns/100ps
module icap_dma_model
  import icap_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic dmaRequest,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic [7:0] slow,
  output logic dmaOwn,
  output logic dmaPsel,
  output logic dmaPenable,
  output int xferCount,
  output logic dmaHang
);
  logic [15:0] mem [0:63];
  int pending = 0;
  // Requests are queued so a stalled channel loses none
  always @(posedge clock)
    if (dmaRequest === 1'b1 && !srst)
      pending++;
  // One buffer read per request; slow stalls before each read
  initial
  begin
    dmaOwn = 1'b0;
    dmaPsel = 1'b0;
    dmaPenable = 1'b0;
    xferCount = 0;
    dmaHang = 1'b0;
    forever
    begin
      @(posedge clock);
      if (pending > 0)
      begin
        repeat (slow) @(posedge clock);
        dmaOwn <= 1'b1;
        dmaPsel <= 1'b1;
        @(posedge clock);
        dmaPenable <= 1'b1;
        @(posedge clock);
        for (int k = 0; k < 20 && pready !== 1'b1; k++)
          @(posedge clock);
        // A read that never answers is flagged for the bench verdict
        if (pready !== 1'b1)
          dmaHang <= 1'b1;
        mem[xferCount[5:0]] = prdata[15:0];
        xferCount++;
        pending--;
        dmaOwn <= 1'b0;
        dmaPsel <= 1'b0;
        dmaPenable <= 1'b0;
      end
    end
  end
endmodule : icap_dma_model

// [testbench/input_capture_dma_pin_regs_bench.sv]
// Self-checking bench for the capture channel with a DMA partner
`timescale 1ns/100ps
`include "icap_map.svh"
module input_capture_dma_pin_regs_bench
  import icap_pkg::*;
  ;
  logic clock, srst, cPsel, cPenable, cPwrite, capturePin, irqEn, sleepActive;
  logic [11:0] cPaddr;
  logic [31:0] cPwdata, prdata, rdData;
  logic pready, pslverr, pinDirection, dmaRequest, wakeRequest, lastErr;
  logic dmaOwn, dmaPsel, dmaPenable, dmaHang, syncTrig;
  logic [7:0] slow;
  logic [15:0] prev, w1;
  int xferCount, base, wakeCount = 0, fail_count = 0, tests_run = 0;
  // No arbitration: scenarios keep the bench idle while DMA requests are enabled
  icap_channel u_icap_channel (
    .clock(clock), .srst(srst), .ce(1'b1), .psel(dmaOwn ? dmaPsel : cPsel),
    .penable(dmaOwn ? dmaPenable : cPenable), .pwrite(dmaOwn ? 1'b0 : cPwrite),
    .paddr(dmaOwn ? `ICAP_OFF_BUF : cPaddr), .pwdata(cPwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capturePin(capturePin),
    .captureIrqEnable(irqEn), .sleepActive(sleepActive), .syncTrigIn(syncTrig),
    .timebaseTick(1'b1), .pinDirection(pinDirection), .dmaRequest(dmaRequest),
    .wakeRequest(wakeRequest));
  icap_dma_model u_icap_dma_model (
    .clock(clock), .srst(srst), .dmaRequest(dmaRequest), .pready(pready),
    .prdata(prdata), .slow(slow), .dmaOwn(dmaOwn), .dmaPsel(dmaPsel),
    .dmaPenable(dmaPenable), .xferCount(xferCount), .dmaHang(dmaHang));
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Wake pulses last one cycle, so count them as they pass
  always @(posedge clock)
    if (wakeRequest === 1'b1)
      wakeCount++;
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask : check
  // Request held until pready is seen; one idle cycle follows
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    cPaddr <= a;
    cPwrite <= w;
    cPwdata <= d;
    cPsel <= 1'b1;
    @(posedge clock);
    cPenable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rdData = prdata;
    lastErr = pslverr;
    if (pready !== 1'b1)
    begin
      fail_count++;
      wrap_up();
    end
    cPsel <= 1'b0;
    cPenable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(a, 1'b1, {16'h0000, d});
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(rdData, exp);
  endtask : rdchk
  // Pin edges twelve cycles apart, so stored timer values step by 12
  task automatic edges(input int n);
    repeat (n)
    begin
      capturePin <= ~capturePin;
      repeat (12) @(posedge clock);
    end
  endtask : edges
  initial
  begin
    srst = 1'b1;
    cPsel = 1'b0;
    cPenable = 1'b0;
    cPwrite = 1'b0;
    cPaddr = 12'h000;
    cPwdata = 32'h0;
    capturePin = 1'b0;
    irqEn = 1'b0;
    sleepActive = 1'b0;
    syncTrig = 1'b0;
    slow = 8'h00;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rdchk(`ICAP_OFF_CON1, 32'h0);
    rdchk(`ICAP_OFF_CON2, 32'hd);
    rdchk(`ICAP_OFF_TMR, 32'h0);
    rdchk(`ICAP_OFF_PIN, 32'h1);
    rdchk(12'h020, 32'h0);
    check({31'h0, lastErr}, 32'h1);
    $display("test reset done");
    wr(`ICAP_OFF_CON1, 16'hffff);
    rdchk(`ICAP_OFF_CON1, 32'h3c67);
    wr(`ICAP_OFF_CON2, 16'hffff);
    rdchk(`ICAP_OFF_CON2, 32'h1df);
    wr(`ICAP_OFF_CON2, 16'h0000);
    wr(`ICAP_OFF_CON1, 16'h0000);
    wr(`ICAP_OFF_TMR, 16'h1234);
    rdchk(`ICAP_OFF_TMR, 32'h1234);
    wr(`ICAP_OFF_PIN, 16'h0000);
    wr(`ICAP_OFF_CON1, 16'h0003);
    rdchk(`ICAP_OFF_PIN, 32'h0);
    check({31'h0, pinDirection}, 32'h0);
    wr(`ICAP_OFF_PIN, 16'h0001);
    $display("test layout done");
    wr(`ICAP_OFF_CON1, 16'h0000);
    wr(`ICAP_OFF_CON2, 16'h0080);
    wr(`ICAP_OFF_CON1, 16'h0003);
    repeat (20) @(posedge clock);
    rdchk(`ICAP_OFF_TMR, 32'h0);
    base = xferCount;
    edges(2);
    repeat (40) @(posedge clock);
    check(xferCount - base, 32'h1);
    check(u_icap_dma_model.mem[base], 32'h0);
    rdchk(`ICAP_OFF_CON1, 32'h3);
    // A sync rise with a source selected releases the held timer
    wr(`ICAP_OFF_CON2, 16'h0081);
    syncTrig <= 1'b1;
    repeat (8) @(posedge clock);
    rdchk(`ICAP_OFF_CON2, 32'hc1);
    syncTrig <= 1'b0;
    $display("test trigger hold done");
    wr(`ICAP_OFF_CON2, 16'h0000);
    wr(`ICAP_OFF_CON1, 16'h0021);
    base = xferCount;
    edges(9);
    rdchk(`ICAP_OFF_CON1, 32'h39);
    check(xferCount - base, 32'h0);
    apb(`ICAP_OFF_BUF, 1'b0, 32'h0);
    check({rdData[31:16], 15'h0000, lastErr}, 32'h0);
    prev = rdData[15:0];
    repeat (7)
    begin
      rdchk(`ICAP_OFF_BUF, {16'h0000, 16'(prev + 16'h000c)});
      prev = rdData[15:0];
    end
    wr(`ICAP_OFF_CON1, 16'h0021);
    rdchk(`ICAP_OFF_CON1, 32'h21);
    $display("test buffer full done");
    wr(`ICAP_OFF_CON1, 16'h0001);
    slow <= 8'h06;
    base = xferCount;
    edges(4);
    repeat (40) @(posedge clock);
    check(xferCount - base, 32'h4);
    for (int i = 1; i < 4; i++)
    begin
      w1 = u_icap_dma_model.mem[base + i];
      check(16'(w1 - u_icap_dma_model.mem[base + i - 1]), 32'hc);
    end
    rdchk(`ICAP_OFF_CON1, 32'h1);
    $display("test dma stream done");
    // Falling-edge and prescaled modes, one capture counted at a time
    wr(`ICAP_OFF_CON1, 16'h0022);
    edges(2);
    rdchk(`ICAP_OFF_CON1, 32'h2a);
    wr(`ICAP_OFF_CON1, 16'h0024);
    edges(6);
    apb(`ICAP_OFF_BUF, 1'b0, 32'h0);
    rdchk(`ICAP_OFF_CON1, 32'h24);
    edges(2);
    rdchk(`ICAP_OFF_CON1, 32'h2c);
    apb(`ICAP_OFF_BUF, 1'b0, 32'h0);
    wr(`ICAP_OFF_CON1, 16'h0025);
    edges(30);
    rdchk(`ICAP_OFF_CON1, 32'h25);
    edges(2);
    rdchk(`ICAP_OFF_CON1, 32'h2d);
    apb(`ICAP_OFF_BUF, 1'b0, 32'h0);
    $display("test prescaler done");
    // Nonzero captures-per-interrupt keeps the DMA off the bus while the bench writes
    sleepActive <= 1'b1;
    wr(`ICAP_OFF_CON1, 16'h0027);
    base = wakeCount;
    edges(2);
    check(wakeCount - base, 32'h0);
    irqEn <= 1'b1;
    edges(2);
    check(wakeCount - base, 32'h1);
    wr(`ICAP_OFF_CON1, 16'h0023);
    edges(2);
    check(wakeCount - base, 32'h1);
    $display("test wake done");
    check({31'h0, dmaHang}, 32'h0);
    wrap_up();
  end
endmodule : input_capture_dma_pin_regs_bench
